// ### hw/strobe_reg.sv
`timescale 1ns/1ps
`include "sync_cal_params.svh"

// Self-clearing strobe register: a write of ones yields a single pulse
module strobe_reg #(
    parameter logic [`REG_W-1:0] USED = 8'hFF
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write side
    input  wire logic              wr_en,
    input  wire logic [`REG_W-1:0] wr_data,
    input  wire logic              force_all,
    // Pulses
    output logic      [`REG_W-1:0] pulse_q
);

    logic [`REG_W-1:0] pulse_d;

    // Zero bits do nothing; unused bits never pulse
    assign pulse_d = force_all ? USED :
                     (wr_en ? (wr_data & USED) : 8'h00);

    // Register returns to zero one cycle after each pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= 8'h00;
        end else begin
            pulse_q <= pulse_d;
        end
    end

endmodule

// ### hw/sync_cal_params.svh
`ifndef SYNC_CAL_PARAMS_SVH
`define SYNC_CAL_PARAMS_SVH

// Bus geometry
`define ADDR_W            16
`define DATA_W            32
`define REG_W             8

// Register indices; byte address is four times the index
`define IDX_LOOP_MODE     14'h0A01
`define IDX_CAL_SYNC      14'h0A02
`define IDX_RESET_FUNC    14'h0A03
`define IDX_IRQ_CLR_SYS   14'h0A04
`define IDX_IRQ_CLR_SYNC  14'h0A05
`define IDX_STATUS        14'h0A10

// Loop mode fields
`define LM_USER_REF_LSB   0
`define LM_USER_REF_MSB   2
`define LM_SEL_MODE_LSB   3
`define LM_SEL_MODE_MSB   4
`define LM_FREERUN_BIT    5
`define LM_HOLDOVER_BIT   6
`define LM_WRITE_MASK     8'h7F
`define LM_RESET          8'h00

// Calibrate and sync fields
`define CS_CAL_BIT        0
`define CS_SYNC_BIT       1
`define CS_WRITE_MASK     8'h03
`define CS_RESET          8'h00

// Reset function strobe bits
`define RF_WATCHDOG_BIT   0
`define RF_ALL_IRQ_BIT    1
`define RF_HISTORY_BIT    2
`define RF_AUTO_SYNC_BIT  3
`define RF_ACCUM_BIT      4
`define RF_DECIM_BIT      5
`define RF_LOOP_FILT_BIT  6
`define RF_USED_MASK      8'h7F

// IRQ clearing layouts
`define IC_SYS_USED_MASK  8'h33
`define IC_SYNC_USED_MASK 8'h0F

// Status fields
`define ST_CAL_BUSY_BIT   0
`define ST_STALL_BIT      1
`define ST_OVERRIDE_BIT   2
`define ST_REF_LSB        4
`define ST_REF_MSB        6

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### hw/sync_cal_pkg.sv
package sync_cal_pkg;

    // Input reference codes
    typedef enum logic [2:0] {
        REF_A  = 3'h0,
        REF_AA = 3'h1,
        REF_B  = 3'h2,
        REF_BB = 3'h3,
        REF_C  = 3'h4,
        REF_CC = 3'h5,
        REF_D  = 3'h6,
        REF_DD = 3'h7
    } ref_sel_t;

    // Reference switching mode
    typedef enum logic [1:0] {
        MODE_AUTO     = 2'h0,
        MODE_FALLBACK = 2'h1,
        MODE_HOLDOVER = 2'h2,
        MODE_MANUAL   = 2'h3
    } sel_mode_t;

    // Calibration sequencer
    typedef enum logic {
        CAL_IDLE,
        CAL_RUN
    } cal_state_t;

endpackage

// ### hw/sync_cal_reset_irq_clear_ctrl.sv
// Functional notes
// (R1) Three-bit reference code A..DD, resets to A
// (R2) User reference steers only in non-automatic modes
// (R3) Sync bit one holds distribution output stalled
// (R4) Sync event fires on sync bit falling
// (R5) Calibrate bit starts system clock PLL calibration
// (R6) System clock stalls until calibration completes
// (R7) Loop filter clear strobe clears loop filter
// (R8) Decimation filter clear strobe clears filter state
// (R9) Accumulator clear strobe zeroes phase accumulator
// (R10) Auto-sync reset strobe restarts sync logic
// (R11) History reset strobe reinitializes tuning-word history
// (R12) All-IRQ reset clears every monitor bit
// (R13) Watchdog reset strobe restarts watchdog timer
// (R14) Software kicks watchdog before timeout expires
// (R15) Reset function bits self-clear after one pulse
// (R16) IRQ clearing bit clears matching monitor bit
// (R17) IRQ clearing bits self-clear after taking effect
// (R18) First clearing register maps system clock events
// (R19) Second clearing register maps sync, watchdog, memory
// (R20) Writing zero to strobes has no effect
`timescale 1ns/1ps
`include "sync_cal_params.svh"

module sync_cal_reset_irq_clear_ctrl
    import sync_cal_pkg::*;
(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write address
    input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [`DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI4-Lite read data
    output logic [`DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Reference selection
    output logic [2:0]               user_ref,
    output logic                     user_ref_override,
    output logic [1:0]               user_sel_mode,
    output logic                     user_freerun,
    output logic                     user_holdover,
    // Distribution sync
    output logic                     dist_stall,
    output logic                     dist_sync_pulse,
    // System clock calibration
    input  wire logic                system_clock_input_pll_enabled,
    input  wire logic                system_clock_input_cal_done,
    output logic                     system_clock_input_cal_start,
    output logic                     system_clock_input_stall,
    // Internal block resets, one-cycle pulses
    output logic                     loop_filter_clear,
    output logic                     decimation_filter_clear,
    output logic                     phase_accum_clear,
    output logic                     auto_sync_reset,
    output logic                     history_reset,
    output logic                     watchdog_restart,
    // IRQ monitor clearing, one-cycle pulses
    output logic                     all_irq_reset,
    output logic [`REG_W-1:0]        irq_clear_system_clock,
    output logic [`REG_W-1:0]        irq_clear_sync_watchdog_nvm
);

    // Write channel state
    logic                 aw_hold_q;
    logic [`ADDR_W-1:0]   aw_addr_q;
    logic                 w_hold_q;
    logic [`DATA_W-1:0]   w_data_q;
    logic [3:0]           w_strb_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;

    // Read channel state
    logic                 rvalid_q;
    logic [`DATA_W-1:0]   rdata_q;
    logic [1:0]           rresp_q;

    // Software registers
    logic [`REG_W-1:0]    loop_mode_q;
    logic [`REG_W-1:0]    cal_sync_q;
    logic                 sync_prev_q;
    logic                 cal_prev_q;
    cal_state_t           cal_state_q;
    cal_state_t           cal_state_d;

    // Strobe vectors
    logic [`REG_W-1:0]    reset_func_pulse;

    // Write channel handshake and decode
    // Each channel stalls once its beat is parked or a response waits
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_hold_q || aw_take;
    wire w_have  = w_hold_q || w_take;
    wire wr_fire = aw_have && w_have && !bvalid_q;

    // Parked beats win over the live ones, so either order works
    wire [`ADDR_W-1:0] wr_addr  = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    wire [`DATA_W-1:0] wr_data  = w_hold_q ? w_data_q : s_axi_wdata;
    wire [3:0]         wr_strb  = w_hold_q ? w_strb_q : s_axi_wstrb;
    wire [13:0]        wr_idx   = wr_addr[`ADDR_W-1:2];
    wire               wr_lane0 = wr_fire && wr_strb[0];
    wire [`REG_W-1:0]  wr_byte  = wr_data[`REG_W-1:0];

    // Register select; a missing lane-0 strobe leaves registers alone
    wire wr_loop_mode  = wr_lane0 && (wr_idx == `IDX_LOOP_MODE);
    wire wr_cal_sync   = wr_lane0 && (wr_idx == `IDX_CAL_SYNC);
    wire wr_reset_func = wr_lane0 && (wr_idx == `IDX_RESET_FUNC);
    wire wr_irq_sys    = wr_lane0 && (wr_idx == `IDX_IRQ_CLR_SYS);
    wire wr_irq_sync   = wr_lane0 && (wr_idx == `IDX_IRQ_CLR_SYNC);
    wire wr_hit = (wr_idx == `IDX_LOOP_MODE) || (wr_idx == `IDX_CAL_SYNC)
               || (wr_idx == `IDX_RESET_FUNC) || (wr_idx == `IDX_IRQ_CLR_SYS)
               || (wr_idx == `IDX_IRQ_CLR_SYNC) || (wr_idx == `IDX_STATUS);

    // Address beat parking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 16'h0000;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end else if (aw_take) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    // Data beat parking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end else if (w_take) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    // Write response; unmapped words answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Stored control registers
    // Loop mode: reference code resets to A
    // (R1) reference field storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_mode_q <= `LM_RESET;
        end else if (wr_loop_mode) begin
            loop_mode_q <= wr_byte & `LM_WRITE_MASK;
        end
    end

    // Calibrate and sync bits hold what software wrote
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_sync_q <= `CS_RESET;
        end else if (wr_cal_sync) begin
            cal_sync_q <= wr_byte & `CS_WRITE_MASK;
        end
    end

    // Reference selection outputs
    assign user_sel_mode = loop_mode_q[`LM_SEL_MODE_MSB:`LM_SEL_MODE_LSB];
    assign user_ref      = loop_mode_q[`LM_USER_REF_MSB:`LM_USER_REF_LSB];
    assign user_freerun  = loop_mode_q[`LM_FREERUN_BIT];
    assign user_holdover = loop_mode_q[`LM_HOLDOVER_BIT];
    // (R2) ignored in automatic mode
    assign user_ref_override = (sel_mode_t'(user_sel_mode) != MODE_AUTO);

    // Distribution sync
    // (R3) stall while bit is one
    assign dist_stall = cal_sync_q[`CS_SYNC_BIT];

    // Sync edge detect; the event is the release, not the set
    // (R4) falling edge event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_prev_q <= 1'b0;
            dist_sync_pulse <= 1'b0;
        end else begin
            sync_prev_q     <= cal_sync_q[`CS_SYNC_BIT];
            dist_sync_pulse <= sync_prev_q && !cal_sync_q[`CS_SYNC_BIT];
        end
    end

    // System clock calibration
    // Only a fresh 0-to-1 of the bit starts a run; a disabled PLL
    // gets no calibration at all
    // (R5) start on bit set
    wire cal_rise = cal_sync_q[`CS_CAL_BIT] && !cal_prev_q
                 && system_clock_input_pll_enabled;

    // Run lasts until the PLL reports done, a few milliseconds
    // (R6) stall until done
    always_comb begin
        cal_state_d = cal_state_q;
        unique case (cal_state_q)
            CAL_IDLE: begin
                if (cal_rise) begin
                    cal_state_d = CAL_RUN;
                end
            end
            CAL_RUN: begin
                if (system_clock_input_cal_done) begin
                    cal_state_d = CAL_IDLE;
                end
            end
        endcase
    end

    // Calibration sequencer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_state_q <= CAL_IDLE;
            cal_prev_q  <= 1'b0;
            system_clock_input_cal_start <= 1'b0;
        end else begin
            cal_state_q      <= cal_state_d;
            cal_prev_q       <= cal_sync_q[`CS_CAL_BIT];
            system_clock_input_cal_start <= (cal_state_q == CAL_IDLE) && cal_rise;
        end
    end

    assign system_clock_input_stall     = (cal_state_q == CAL_RUN);

    // Self-clearing strobes
    // (R15) one pulse per write
    // (R20) zero bits ignored
    strobe_reg #(
        .USED      (`RF_USED_MASK)
    ) u_reset_func (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (wr_reset_func),
        .wr_data   (wr_byte),
        .force_all (1'b0),
        .pulse_q   (reset_func_pulse)
    );

    // (R7) loop filter clear
    assign loop_filter_clear       = reset_func_pulse[`RF_LOOP_FILT_BIT];
    // (R8) decimation filter clear
    assign decimation_filter_clear = reset_func_pulse[`RF_DECIM_BIT];
    // (R9) accumulator clear
    assign phase_accum_clear       = reset_func_pulse[`RF_ACCUM_BIT];
    // (R10) auto-sync reset
    assign auto_sync_reset         = reset_func_pulse[`RF_AUTO_SYNC_BIT];
    // (R11) history reset
    assign history_reset           = reset_func_pulse[`RF_HISTORY_BIT];
    // (R13) watchdog restart pulse
    assign watchdog_restart        = reset_func_pulse[`RF_WATCHDOG_BIT];
    // (R12) clear all monitors
    assign all_irq_reset           = reset_func_pulse[`RF_ALL_IRQ_BIT];

    // IRQ clearing: all-IRQ reset acts as ones in every used bit; the
    // force is taken from the write itself so both pulses line up
    // (R16) clear matching monitor bit
    // (R17) self-clearing
    // (R18) system clock layout
    strobe_reg #(
        .USED      (`IC_SYS_USED_MASK)
    ) u_irq_sys (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (wr_irq_sys),
        .wr_data   (wr_byte),
        .force_all (wr_reset_func && wr_byte[`RF_ALL_IRQ_BIT]),
        .pulse_q   (irq_clear_system_clock)
    );

    // (R19) sync, watchdog, memory layout
    // (R12) force all clearing bits
    strobe_reg #(
        .USED      (`IC_SYNC_USED_MASK)
    ) u_irq_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (wr_irq_sync),
        .wr_data   (wr_byte),
        .force_all (wr_reset_func && wr_byte[`RF_ALL_IRQ_BIT]),
        .pulse_q   (irq_clear_sync_watchdog_nvm)
    );

    // Read channel
    wire [13:0] rd_idx  = s_axi_araddr[`ADDR_W-1:2];
    assign s_axi_arready = !rvalid_q;
    wire        rd_take = s_axi_arvalid && s_axi_arready;

    // Live status: calibration and distribution stall, override flag and user reference code
    wire [`REG_W-1:0] status_byte = {1'b0, user_ref, 1'b0,
                                     user_ref_override, dist_stall,
                                     system_clock_input_stall};

    // Strobe registers read zero since they never hold a value
    wire [`REG_W-1:0] rd_byte =
        (rd_idx == `IDX_LOOP_MODE) ? loop_mode_q :
        (rd_idx == `IDX_CAL_SYNC)  ? cal_sync_q  :
        (rd_idx == `IDX_STATUS)    ? status_byte :
        8'h00;
    wire rd_hit = (rd_idx == `IDX_LOOP_MODE) || (rd_idx == `IDX_CAL_SYNC)
               || (rd_idx == `IDX_RESET_FUNC) || (rd_idx == `IDX_IRQ_CLR_SYS)
               || (rd_idx == `IDX_IRQ_CLR_SYNC) || (rd_idx == `IDX_STATUS);

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule

// ### testbench/sync_cal_props.sv
`timescale 1ns/1ps
`include "sync_cal_params.svh"

// Watches the strobe, sync and calibration outputs of the block
module sync_cal_props (
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Observed ports
    input wire logic              s_axi_bvalid,
    input wire logic              user_ref_override,
    input wire logic [1:0]        user_sel_mode,
    input wire logic              dist_stall,
    input wire logic              dist_sync_pulse,
    input wire logic              system_clock_input_cal_done,
    input wire logic              system_clock_input_cal_start,
    input wire logic              system_clock_input_stall,
    input wire logic              loop_filter_clear,
    input wire logic              decimation_filter_clear,
    input wire logic              phase_accum_clear,
    input wire logic              auto_sync_reset,
    input wire logic              history_reset,
    input wire logic              watchdog_restart,
    input wire logic              all_irq_reset,
    input wire logic [`REG_W-1:0] irq_clear_system_clock,
    input wire logic [`REG_W-1:0] irq_clear_sync_watchdog_nvm
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Any strobe, so pulses can be tied to the write answer
    wire any_strobe = |{loop_filter_clear, decimation_filter_clear,
        phase_accum_clear, auto_sync_reset, history_reset,
        watchdog_restart, all_irq_reset, irq_clear_system_clock,
        irq_clear_sync_watchdog_nvm};

    chk_strobe_on_write: assert property (
        any_strobe |-> $rose(s_axi_bvalid))
        else $error("strobe without fresh write answer");
    chk_strobe_one_cycle: assert property (
        any_strobe |=> !any_strobe)
        else $error("strobe held too long");
    chk_all_irq_map: assert property (
        all_irq_reset |-> irq_clear_system_clock == 8'h33
        && irq_clear_sync_watchdog_nvm == 8'h0F)
        else $error("all irq reset missed a bit");
    chk_unused_clear: assert property (
        (irq_clear_system_clock & 8'hCC) == 8'h00
        && (irq_clear_sync_watchdog_nvm & 8'hF0) == 8'h00)
        else $error("unused clearing bit pulsed");
    chk_override_mode: assert property (
        user_ref_override == (user_sel_mode != 2'h0))
        else $error("override not following mode");
    chk_sync_on_fall: assert property (
        $fell(dist_stall) |-> ##[1:3] dist_sync_pulse)
        else $error("no sync event after release");
    chk_sync_not_set: assert property (
        dist_sync_pulse |-> !dist_stall)
        else $error("sync event while stall set");
    chk_cal_start_stall: assert property (
        system_clock_input_cal_start |-> system_clock_input_stall)
        else $error("calibration start without stall");
    chk_stall_holds: assert property (
        system_clock_input_stall && !system_clock_input_cal_done |=> system_clock_input_stall)
        else $error("stall dropped early");
    chk_stall_ends: assert property (
        system_clock_input_stall && system_clock_input_cal_done && !system_clock_input_cal_start
        |=> !system_clock_input_stall)
        else $error("stall kept after done");
endmodule

bind sync_cal_reset_irq_clear_ctrl sync_cal_props sync_cal_props_i (.*);

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "sync_cal_params.svh"

module tb;
    import sync_cal_pkg::*;

    // Table row: register, data written, pulses expected
    typedef struct packed {
        logic [13:0] idx;
        logic [7:0]  d;
        logic [6:0]  rf;
        logic [7:0]  c1;
        logic [7:0]  c2;
    } row_t;

    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, user_ref_override;
    logic        user_freerun, user_holdover, dist_stall, dist_sync_pulse;
    logic        system_clock_input_pll_enabled, system_clock_input_cal_done, system_clock_input_cal_start;
    logic        system_clock_input_stall, loop_filter_clear, decimation_filter_clear;
    logic        phase_accum_clear, auto_sync_reset, history_reset;
    logic        watchdog_restart, all_irq_reset;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  s_axi_awprot, s_axi_arprot, user_ref;
    logic [1:0]  s_axi_bresp, s_axi_rresp, user_sel_mode, resp;
    logic [7:0]  irq_clear_system_clock, irq_clear_sync_watchdog_nvm;
    logic [7:0]  seen_c1, seen_c2;
    logic [6:0]  seen_rf;
    int          bad_count, compares, pulse_cyc, sync_cnt, cal_cnt, cyc;

    // Strobe rows
    row_t rows [16] = '{
        '{`IDX_RESET_FUNC, 8'h01, 7'h01, 8'h00, 8'h00},
        '{`IDX_RESET_FUNC, 8'h02, 7'h02, 8'h33, 8'h0F},
        '{`IDX_RESET_FUNC, 8'h04, 7'h04, 8'h00, 8'h00},
        '{`IDX_RESET_FUNC, 8'h08, 7'h08, 8'h00, 8'h00},
        '{`IDX_RESET_FUNC, 8'h10, 7'h10, 8'h00, 8'h00},
        '{`IDX_RESET_FUNC, 8'h20, 7'h20, 8'h00, 8'h00},
        '{`IDX_RESET_FUNC, 8'h40, 7'h40, 8'h00, 8'h00},
        '{`IDX_RESET_FUNC, 8'hFF, 7'h7F, 8'h33, 8'h0F},
        '{`IDX_RESET_FUNC, 8'h00, 7'h00, 8'h00, 8'h00},
        '{`IDX_IRQ_CLR_SYS, 8'hFF, 7'h00, 8'h33, 8'h00},
        '{`IDX_IRQ_CLR_SYS, 8'h20, 7'h00, 8'h20, 8'h00},
        '{`IDX_IRQ_CLR_SYS, 8'h13, 7'h00, 8'h13, 8'h00},
        '{`IDX_IRQ_CLR_SYS, 8'h00, 7'h00, 8'h00, 8'h00},
        '{`IDX_IRQ_CLR_SYNC, 8'hFF, 7'h00, 8'h00, 8'h0F},
        '{`IDX_IRQ_CLR_SYNC, 8'h08, 7'h00, 8'h00, 8'h08},
        '{`IDX_IRQ_CLR_SYNC, 8'h05, 7'h00, 8'h00, 8'h05}};

    sync_cal_reset_irq_clear_ctrl sync_cal_reset_irq_clear_ctrl_i (.*);

    // Clock, 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Pulses gathered mid-cycle, clear of the edge updates
    wire [6:0] rf_now = {loop_filter_clear, decimation_filter_clear,
        phase_accum_clear, auto_sync_reset, history_reset, all_irq_reset,
        watchdog_restart};
    always @(negedge aclk) begin
        seen_rf = seen_rf | rf_now;
        seen_c1 = seen_c1 | irq_clear_system_clock;
        seen_c2 = seen_c2 | irq_clear_sync_watchdog_nvm;
        if (|{rf_now, irq_clear_system_clock, irq_clear_sync_watchdog_nvm})
            pulse_cyc++;
        sync_cnt += dist_sync_pulse;
        cal_cnt += system_clock_input_cal_start;
    end

    // Hang guard, far above the length of the sequence
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [13:0] idx, input logic [7:0] d);
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_go = 1'b0;
        while (!b_go) begin
            #1;
            aw_go = s_axi_awvalid && s_axi_awready;
            w_go = s_axi_wvalid && s_axi_wready;
            b_go = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_go) s_axi_awvalid <= 1'b0;
            if (w_go) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [13:0] idx);
        logic ar_go, r_go;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_go = 1'b0;
        while (!r_go) begin
            #1;
            ar_go = s_axi_arvalid && s_axi_arready;
            r_go = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_go) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} <= 4'h0;
        {s_axi_rready, system_clock_input_cal_done, aresetn} <= 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 64'h0;
        {s_axi_awprot, s_axi_arprot} <= 6'h0;
        s_axi_wstrb <= 4'hF;
        system_clock_input_pll_enabled <= 1'b1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`IDX_LOOP_MODE);
        check(rd, 32'h0);
        check(user_ref, 32'h0);
        // Ordinary strobe writes from the table
        foreach (rows[i]) begin
            {seen_rf, seen_c1, seen_c2, pulse_cyc} = '0;
            axi_write(rows[i].idx, rows[i].d);
            check(resp, `RESP_OKAY);
            repeat (2) @(posedge aclk);
            check(seen_rf, rows[i].rf);
            check(seen_c1, rows[i].c1);
            check(seen_c2, rows[i].c2);
            check(pulse_cyc, |{rows[i].rf, rows[i].c1, rows[i].c2});
            axi_read(rows[i].idx);
            check(rd, 32'h0);
        end
        // Every reference code, each under the selection mode given by its low two bits
        for (int i = 0; i < 8; i++) begin
            axi_write(`IDX_LOOP_MODE, {1'b0, i[1:0], i[1:0], i[2:0]});
            @(posedge aclk);
            check(user_ref, i[2:0]);
            check(user_sel_mode, i[1:0]);
            check({user_holdover, user_freerun}, i[1:0]);
            check(user_ref_override, i[1:0] != 2'h0);
        end
        axi_read(`IDX_LOOP_MODE);
        check(rd, 32'h7F);
        axi_read(`IDX_STATUS);
        check(rd, 32'h74);
        // Distribution sync: stall while set, event on release
        sync_cnt = 0;
        axi_write(`IDX_CAL_SYNC, 8'h02);
        repeat (3) @(posedge aclk);
        check(dist_stall, 1'b1);
        check(sync_cnt, 0);
        axi_read(`IDX_CAL_SYNC);
        check(rd, 32'h2);
        axi_write(`IDX_CAL_SYNC, 8'h00);
        repeat (4) @(posedge aclk);
        check(dist_stall, 1'b0);
        check(sync_cnt, 1);
        // Calibration: start, stall until done, then none while disabled
        cal_cnt = 0;
        axi_write(`IDX_CAL_SYNC, 8'h01);
        repeat (20) @(posedge aclk);
        check(cal_cnt, 1);
        check(system_clock_input_stall, 1'b1);
        system_clock_input_cal_done <= 1'b1;
        @(posedge aclk);
        system_clock_input_cal_done <= 1'b0;
        repeat (2) @(posedge aclk);
        check(system_clock_input_stall, 1'b0);
        axi_write(`IDX_CAL_SYNC, 8'h00);
        system_clock_input_pll_enabled <= 1'b0;
        axi_write(`IDX_CAL_SYNC, 8'h01);
        repeat (4) @(posedge aclk);
        check(cal_cnt, 1);
        // Unmapped place answers an error and reads zero
        axi_write(14'h0000, 8'hFF);
        check(resp, `RESP_SLVERR);
        axi_read(14'h0000);
        check(resp, `RESP_SLVERR);
        check(rd, 32'h0);
        // Reset in mid-run brings stall and reference back to defaults
        axi_write(`IDX_CAL_SYNC, 8'h02);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({dist_stall, user_ref}, 4'h0);
        check(sync_cnt, 1);
        final_report();
    end
endmodule
